/* File: include/csio_cfg.svh */
// Purpose: Constants for the clocked serial port and its controller
// Assumes: 100 MHz clk
// Notes: Register offsets are byte addresses on the AXI4-Lite side
`ifndef CSIO_CFG_SVH
`define CSIO_CFG_SVH
`define CSIO_MODE_OFF 8'hf6
`define CSIO_SEL_LSB 0
`define CSIO_EN_BIT 2
`define CSIO_RDY_BIT 3
`define CSIO_MODE_RST 8'h00
`define CSIO_CNT_LOAD 3'h7
`define CSIO_BITS 8
`define CSIO_INT_DIV 4
`define CSIO_EXT_MAX_KHZ 250
`define CSIO_CLK_MHZ 100
`define CSIO_EXT_HALF_CYC ((`CSIO_CLK_MHZ * 1000 + 2 * `CSIO_EXT_MAX_KHZ - 1) / (2 * `CSIO_EXT_MAX_KHZ))
`define CSIO_A_CTRL 8'h00
`define CSIO_A_DATA 8'h04
`define CSIO_A_STAT 8'h08
`define CSIO_A_MASK 8'h0c
`define CSIO_A_MODE 8'h10
`define CSIO_A_RX 8'h14
`endif

/* File: include/csio_pkg.sv */
// Purpose: Types shared by both ends
// Assumes: Nothing
// Notes: Clock source encodings of the mode register
package csio_pkg;
    typedef enum logic [1:0] {
        CSIO_SRC_EXT0 = 2'h0,
        CSIO_SRC_EXT1 = 2'h1,
        CSIO_SRC_TMR = 2'h2,
        CSIO_SRC_SYS = 2'h3
    } csio_src_t;
    typedef enum logic [2:0] {
        CSIO_H_IDLE = 3'h1,
        CSIO_H_LOW = 3'h2,
        CSIO_H_HIGH = 3'h4
    } csio_hst_t;
endpackage : csio_pkg

/* File: include/csio_if.sv */
// Purpose: Link between serial port and far party
// Assumes: Wire levels resolved by the bench from enables
// Notes: Enables are active low; pins idle high by pull-up
`timescale 1ns/10ps
interface csio_if;
    logic devClkO;
    logic devClkOeN;
    logic devOut;
    logic devOutOeN;
    logic devRdyN;
    logic devRdyOeN;
    logic farClkO;
    logic farClkOeN;
    logic farOut;
    logic farOutOeN;
    logic shiftClkPin;
    logic outPin;
    logic inPin;
    logic readyPin;
    modport dev (
        output devClkO, devClkOeN, devOut, devOutOeN, devRdyN, devRdyOeN,
        input shiftClkPin, inPin
    );
    modport far (
        output farClkO, farClkOeN, farOut, farOutOeN,
        input shiftClkPin, outPin, readyPin
    );
endinterface : csio_if

/* File: design/csio_port.sv */
// Purpose: Eight-bit clocked serial port, device end
// Assumes: Pins asynchronous to clk; timer overflow pulse from clk domain
// Notes: Pin enables active low; every output registered
// Behaviour
// - Mode low bits select clock; 00/01 external
// - Select 10: timer overflow halved
// - Select 11: system clock over four
// - Mode bit 2 enables serial pins
// - Clock driven out when internal source
// - Input pin direction set to input
// - Mode bit 3 enables ready output, internal clock only
// - Ready low after write, high next fall
// - Register write loads counter with seven
// - Out on falling, sample on rising edge
// - Shift out least significant bit first
// - Internal: stop clock high after eight
// - External: interrupt after eight, party limits
// - External clock at most 250kHz, 50%
// - External clock idles high between transfers
// - Interrupt on a rise taken with bit counter at zero
`timescale 1ns/10ps
`include "csio_cfg.svh"
module csio_port (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Register access
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic dataWr,
    output logic [7:0] regRdata,
    output logic [7:0] dataRdata,
    // Events
    input wire logic tmrOvf,
    output logic doneIrq,
    output logic busy,
    // Link
    csio_if.dev lnk
);
    logic [7:0] mode_r;
    logic [7:0] shift_r;
    logic [2:0] cnt_r;
    logic active_r;
    logic sclk_r;
    logic [1:0] div_r;
    logic [1:0] pinClkSync_r;
    logic [1:0] pinInSync_r;
    logic extClkPrev_r;
    logic rdyN_r;
    logic inBit_r;
    logic intSrc;
    logic serEn;
    logic tick;
    logic fallEv;
    logic riseEv;
    csio_pkg::csio_src_t src;

    assign src = csio_pkg::csio_src_t'(mode_r[`CSIO_SEL_LSB +: 2]);
    assign intSrc = src[1];
    assign serEn = mode_r[`CSIO_EN_BIT];

    // Internal clock ticks: half periods of the shift clock
    always_comb begin
        case (src)
            csio_pkg::CSIO_SRC_TMR: tick = tmrOvf;
            csio_pkg::CSIO_SRC_SYS: tick = (div_r == 2'h1) || (div_r == 2'h3);
            default: tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinClkSync_r <= 2'h3;
            pinInSync_r <= 2'h3;
            extClkPrev_r <= 1'b1;
        end else begin
            pinClkSync_r <= {pinClkSync_r[0], lnk.shiftClkPin};
            pinInSync_r <= {pinInSync_r[0], lnk.inPin};
            extClkPrev_r <= pinClkSync_r[1];
        end
    end

    // Shift-clock edges, from the divider or the synced pin
    always_comb begin
        fallEv = 1'b0;
        riseEv = 1'b0;
        if (serEn && intSrc) begin
            fallEv = active_r && tick && sclk_r;
            riseEv = active_r && tick && !sclk_r;
        end else if (serEn) begin
            // Pin edges are seen two cycles late
            fallEv = extClkPrev_r && !pinClkSync_r[1];
            riseEv = !extClkPrev_r && pinClkSync_r[1];
        end
    end

    // Internal shift clock generator, parked high when idle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_r <= 1'b1;
        end else if (!active_r || !intSrc) begin
            sclk_r <= 1'b1;
        end else if (dataWr) begin
            // Reload parks the clock so bit 0 leads
            sclk_r <= 1'b1;
        end else if (fallEv) begin
            sclk_r <= 1'b0;
        end else if (riseEv) begin
            sclk_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= `CSIO_MODE_RST;
        end else if (regWr && regAddr == `CSIO_MODE_OFF) begin
            mode_r <= regWdata;
        end
    end

    // Shift register, counter and completion
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_r <= 8'h00;
            cnt_r <= 3'h0;
            active_r <= 1'b0;
        end else begin
            if (dataWr) begin
                shift_r <= regWdata;
                cnt_r <= `CSIO_CNT_LOAD;
                active_r <= 1'b1;
            end else if (active_r && riseEv) begin
                shift_r <= {pinInSync_r[1], shift_r[7:1]};
                cnt_r <= cnt_r - 3'h1;
                if (cnt_r == 3'h0) begin
                    active_r <= 1'b0;
                end
            end
        end
    end

    // Completion pulse on the eighth rising edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doneIrq <= 1'b0;
        end else begin
            doneIrq <= !dataWr && active_r && riseEv && (cnt_r == 3'h0);
        end
    end

    // Output bit moves on falling edges only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            inBit_r <= 1'b1;
        end else if (fallEv) begin
            inBit_r <= shift_r[0];
        end
    end

    // Ready output: low from write until next falling edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdyN_r <= 1'b1;
        end else if (dataWr) begin
            rdyN_r <= 1'b0;
        end else if (fallEv) begin
            rdyN_r <= 1'b1;
        end
    end

    // Pin drivers, enables active low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lnk.devClkO <= 1'b1;
            lnk.devClkOeN <= 1'b1;
            lnk.devOut <= 1'b1;
            lnk.devOutOeN <= 1'b1;
            lnk.devRdyN <= 1'b1;
            lnk.devRdyOeN <= 1'b1;
        end else begin
            lnk.devClkO <= sclk_r;
            lnk.devClkOeN <= !(serEn && intSrc);
            lnk.devOut <= inBit_r;
            lnk.devOutOeN <= !serEn;
            lnk.devRdyN <= rdyN_r;
            lnk.devRdyOeN <= !(mode_r[`CSIO_RDY_BIT] && intSrc);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 8'h00;
            dataRdata <= 8'h00;
            busy <= 1'b0;
        end else begin
            regRdata <= (regRd && regAddr == `CSIO_MODE_OFF) ? mode_r : 8'h00;
            dataRdata <= shift_r;
            busy <= active_r;
        end
    end
endmodule : csio_port

/* File: design/csio_far.sv */
// Purpose: Far party: external clock master with AXI4-Lite control
// Assumes: Device set to external clock; pins asynchronous
// Notes: Sends eight pulses per byte, clock idles high
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "csio_cfg.svh"
module csio_far #(
    parameter int HALF_CYC = `CSIO_EXT_HALF_CYC
) (
    // System
    input wire logic clk,
    input wire logic resetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq,
    // Link
    csio_if.far lnk
);
    csio_pkg::csio_hst_t st_r;
    logic [15:0] hcnt_r;
    logic [2:0] bit_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic [1:0] inSync_r;
    logic [1:0] rdySync_r;
    logic awHave_r;
    logic wHave_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic startReq;
    logic doneEv;
    logic wrDo;

    assign wrDo = awHave_r && wHave_r && !s_axi_bvalid;
    assign startReq = wrDo && awAddr_r == `CSIO_A_DATA && st_r == csio_pkg::CSIO_H_IDLE;
    assign doneEv = st_r == csio_pkg::CSIO_H_HIGH && hcnt_r == 16'h0 && bit_r == 3'h7;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            inSync_r <= 2'h3;
            rdySync_r <= 2'h3;
        end else begin
            inSync_r <= {inSync_r[0], lnk.outPin};
            rdySync_r <= {rdySync_r[0], lnk.readyPin};
        end
    end

    // Clock master: eight pulses, then idle high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= csio_pkg::CSIO_H_IDLE;
            hcnt_r <= 16'h0;
            bit_r <= 3'h0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
        end else begin
            case (st_r)
                csio_pkg::CSIO_H_IDLE: begin
                    if (startReq) begin
                        tx_r <= wData_r[7:0];
                        bit_r <= 3'h0;
                        hcnt_r <= 16'(HALF_CYC - 1);
                        st_r <= csio_pkg::CSIO_H_LOW;
                    end
                end
                csio_pkg::CSIO_H_LOW: begin
                    if (hcnt_r == 16'h0) begin
                        rx_r <= {inSync_r[1], rx_r[7:1]};
                        hcnt_r <= 16'(HALF_CYC - 1);
                        st_r <= csio_pkg::CSIO_H_HIGH;
                    end else begin
                        hcnt_r <= hcnt_r - 16'h1;
                    end
                end
                csio_pkg::CSIO_H_HIGH: begin
                    if (hcnt_r != 16'h0) begin
                        hcnt_r <= hcnt_r - 16'h1;
                    end else if (bit_r == 3'h7) begin
                        st_r <= csio_pkg::CSIO_H_IDLE;
                    end else begin
                        bit_r <= bit_r + 3'h1;
                        tx_r <= {1'b1, tx_r[7:1]};
                        hcnt_r <= 16'(HALF_CYC - 1);
                        st_r <= csio_pkg::CSIO_H_LOW;
                    end
                end
                default: st_r <= csio_pkg::CSIO_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lnk.farClkO <= 1'b1;
            lnk.farClkOeN <= 1'b0;
            lnk.farOut <= 1'b1;
            lnk.farOutOeN <= 1'b0;
        end else begin
            lnk.farClkO <= st_r != csio_pkg::CSIO_H_LOW;
            lnk.farClkOeN <= 1'b0;
            lnk.farOut <= tx_r[0];
            lnk.farOutOeN <= 1'b0;
        end
    end

    // Status: bit0 byte done, bit1 device ready seen low; W1C, set wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat_r <= 2'h0;
            mask_r <= 2'h0;
            irq <= 1'b0;
        end else begin
            if (wrDo && awAddr_r == `CSIO_A_STAT) begin
                stat_r <= (stat_r & ~wData_r[1:0]) | {!rdySync_r[1], doneEv};
            end else begin
                stat_r <= stat_r | {!rdySync_r[1], doneEv};
            end
            if (wrDo && awAddr_r == `CSIO_A_MASK) begin
                mask_r <= wData_r[1:0];
            end
            irq <= |(stat_r & mask_r);
        end
    end

    // AXI4-Lite write path
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !awHave_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHave_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
            end
            if (wrDo) begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_r > `CSIO_A_RX) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case ({s_axi_araddr[7:2], 2'h0})
                    `CSIO_A_CTRL: s_axi_rdata <= {31'h0, st_r != csio_pkg::CSIO_H_IDLE};
                    `CSIO_A_DATA: s_axi_rdata <= {24'h0, tx_r};
                    `CSIO_A_STAT: s_axi_rdata <= {30'h0, stat_r};
                    `CSIO_A_MASK: s_axi_rdata <= {30'h0, mask_r};
                    `CSIO_A_MODE: s_axi_rdata <= {31'h0, rdySync_r[1]};
                    `CSIO_A_RX: s_axi_rdata <= {24'h0, rx_r};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : csio_far

/* File: verification/csio_link_checker.sv */
// Purpose: Pin-level checks on the link between the serial port and the far party
// Assumes: Far clock half period set to 8 cycles
// Notes: Watches interface signals only
`timescale 1ns/10ps
module csio_link_checker (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Device pins
    input wire logic devClkO,
    input wire logic devClkOeN,
    input wire logic devOut,
    input wire logic devOutOeN,
    input wire logic devRdyN,
    input wire logic devRdyOeN,
    // Far pins
    input wire logic farClkO
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_out_clk_low: assert property (!devClkOeN && !devOutOeN && $changed(devOut) |-> !devClkO)
        else $error("device data moved while its clock was high");
    a_rdy_fall_idle: assert property (!devRdyOeN && $fell(devRdyN) |-> devClkO)
        else $error("ready fell while clock low");
    a_rdy_rise_fall: assert property (!devRdyOeN && $rose(devRdyN) |-> !devClkO)
        else $error("ready rose away from a falling clock");
    a_rdy_int_only: assert property (!devRdyOeN |-> !devClkOeN)
        else $error("ready driven without internal clock");
    a_pins_enabled: assert property (!devClkOeN |-> !devOutOeN)
        else $error("clock driven while data pin off");
    a_clk_low_two: assert property (!devClkOeN && $fell(devClkO) |=> !devClkO)
        else $error("device clock low phase too short");
    a_far_low_half: assert property ($fell(farClkO) |-> !farClkO [*8] ##1 farClkO)
        else $error("far clock low phase not eight cycles");
    a_far_high_half: assert property ($rose(farClkO) |-> farClkO [*8])
        else $error("far clock high phase too short");
endmodule : csio_link_checker

/* File: verification/clocked_serial_io_port_bench.sv */
// Purpose: Self-checking bench joining the serial port to the far party
// Assumes: Far half period of 8 cycles, timer pulse every 3 cycles
// Notes: Wire levels resolved here from the enables, pull-up when released
`timescale 1ns/10ps
`include "csio_cfg.svh"
module clocked_serial_io_port_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic regWr = 1'b0, regRd = 1'b0, dataWr = 1'b0, tmrOvf = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, dataRdata;
    logic doneIrq, busy, irq;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0, rData, d;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp, r;
    logic [1:0] tDiv = 2'h0;
    logic clkPrev = 1'b1;
    logic [7:0] capOut = 8'h00, capIn = 8'h00;
    int falls = 0, dones = 0, rdyLows = 0, cyc = 0, miscompares = 0, checked = 0;

    always #5 clk = ~clk;

    csio_if csio_if_i ();
    assign csio_if_i.shiftClkPin = !csio_if_i.devClkOeN ? csio_if_i.devClkO
                                 : (!csio_if_i.farClkOeN ? csio_if_i.farClkO : 1'b1);
    assign csio_if_i.outPin = !csio_if_i.devOutOeN ? csio_if_i.devOut : 1'b1;
    assign csio_if_i.inPin = !csio_if_i.farOutOeN ? csio_if_i.farOut : 1'b1;
    assign csio_if_i.readyPin = !csio_if_i.devRdyOeN ? csio_if_i.devRdyN : 1'b1;

    csio_port csio_port_i (.clk(clk), .resetn(resetn), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWdata(regWdata), .dataWr(dataWr), .regRdata(regRdata), .dataRdata(dataRdata), .tmrOvf(tmrOvf),
        .doneIrq(doneIrq), .busy(busy), .lnk(csio_if_i.dev));
    csio_far #(.HALF_CYC(8)) csio_far_i (.clk(clk), .resetn(resetn), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .irq(irq), .lnk(csio_if_i.far));
    csio_link_checker csio_link_checker_i (.clk(clk), .resetn(resetn), .devClkO(csio_if_i.devClkO),
        .devClkOeN(csio_if_i.devClkOeN), .devOut(csio_if_i.devOut), .devOutOeN(csio_if_i.devOutOeN),
        .devRdyN(csio_if_i.devRdyN), .devRdyOeN(csio_if_i.devRdyOeN), .farClkO(csio_if_i.farClkO));

    // Timer overflow stand-in
    always @(posedge clk) begin
        tDiv <= (tDiv == 2'h2) ? 2'h0 : tDiv + 2'h1;
        tmrOvf <= (tDiv == 2'h2);
    end

    // Wire monitor and run limit
    always @(posedge clk) begin
        clkPrev <= csio_if_i.shiftClkPin;
        if (clkPrev && !csio_if_i.shiftClkPin) falls <= falls + 1;
        if (!clkPrev && csio_if_i.shiftClkPin) begin
            capOut <= {csio_if_i.outPin, capOut[7:1]};
            capIn <= {csio_if_i.inPin, capIn[7:1]};
        end
        if (doneIrq === 1'b1) dones <= dones + 1;
        if (csio_if_i.readyPin === 1'b0) rdyLows <= rdyLows + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp

    function automatic logic [7:0] mode_of(input logic rdy, input logic en, input csio_pkg::csio_src_t s);
        return {4'h0, rdy, en, s};
    endfunction : mode_of

    task dev_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : dev_wr

    task dev_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 cmp(32'(regRdata), 32'(e));
    endtask : dev_rd

    task dev_load(input logic [7:0] v);
        @(posedge clk);
        dataWr <= 1'b1;
        regWdata <= v;
        @(posedge clk);
        dataWr <= 1'b0;
    endtask : dev_load

    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awReady === 1'b1) begin
                aw = 1'b1;
                awValid <= 1'b0;
            end
            if (!w && wReady === 1'b1) begin
                w = 1'b1;
                wValid <= 1'b0;
            end
        end
        while (bValid !== 1'b1) @(posedge clk);
        r = bResp;
        bReady <= 1'b0;
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge clk);
            if (arReady === 1'b1) arValid <= 1'b0;
        end while (rValid !== 1'b1);
        v = rData;
        rs = rResp;
        rReady <= 1'b0;
    endtask : axi_rd

    task irq_chk(input logic e);
        repeat (2) @(posedge clk);
        #1 cmp(32'(irq), 32'(e));
    endtask : irq_chk

    task run_int(input logic [7:0] m, input logic [7:0] v, input int lo, input int hi);
        int f0, n0, c0, r0;
        dev_wr(`CSIO_MODE_OFF, m);
        f0 = falls;
        n0 = dones;
        c0 = cyc;
        r0 = rdyLows;
        dev_load(v);
        repeat (3) @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
        cmp(32'((cyc - c0) >= lo && (cyc - c0) <= hi), 32'h1);
        repeat (4) @(posedge clk);
        #1 cmp(32'(falls - f0), 32'h8);
        cmp(32'(dones - n0), 32'h1);
        cmp(32'(capOut), 32'(v));
        cmp(32'(csio_if_i.shiftClkPin & csio_if_i.readyPin), 32'h1);
        cmp(32'(rdyLows != r0), 32'(m[3]));
        $display("test internal mode %h done", m);
    endtask : run_int

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        dev_rd(`CSIO_MODE_OFF, 8'h00);
        dev_rd(8'h33, 8'h00);
        axi_rd(8'h18, d, r);
        cmp(32'(r), 32'h2);
        axi_wr(8'h18, 32'h0);
        cmp(32'(r), 32'h2);
        axi_wr(`CSIO_A_MASK, 32'h0);
        cmp(32'(r), 32'h0);
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            dev_wr(`CSIO_MODE_OFF, mode_of(1'b0, 1'b1, csio_pkg::csio_src_t'(2'(s))));
            dev_load(8'ha5 ^ 8'(s));
            axi_wr(`CSIO_A_MASK, 32'h1);
            axi_wr(`CSIO_A_DATA, 32'h3c + 32'(s));
            axi_rd(`CSIO_A_CTRL, d, r);
            cmp(d, 32'h1);
            while (irq !== 1'b1) @(posedge clk);
            repeat (8) @(posedge clk);
            axi_rd(`CSIO_A_RX, d, r);
            cmp(d, 32'ha5 ^ 32'(s));
            cmp(32'(capIn), 32'h3c + 32'(s));
            cmp(32'(dataRdata), 32'h3c + 32'(s));
            cmp(32'(dones), 32'(s + 1));
            cmp(32'(csio_if_i.shiftClkPin), 32'h1);
            axi_wr(`CSIO_A_MASK, 32'h0);
            irq_chk(1'b0);
            axi_wr(`CSIO_A_MASK, 32'h1);
            irq_chk(1'b1);
            axi_wr(`CSIO_A_STAT, 32'h1);
            irq_chk(1'b0);
            $display("test external select %0d done", s);
        end
        run_int(mode_of(1'b1, 1'b1, csio_pkg::CSIO_SRC_SYS), 8'h5a, 32, 42);
        axi_rd(`CSIO_A_STAT, d, r);
        cmp(32'(d[1]), 32'h1);
        run_int(mode_of(1'b0, 1'b1, csio_pkg::CSIO_SRC_TMR), 8'hc3, 46, 60);
        dev_wr(`CSIO_MODE_OFF, mode_of(1'b0, 1'b0, csio_pkg::CSIO_SRC_SYS));
        d = 32'(falls);
        dev_load(8'h81);
        repeat (60) @(posedge clk);
        cmp(32'(falls) - d, 32'h0);
        cmp(32'(csio_if_i.outPin), 32'h1);
        cmp(32'(dones), 32'h4);
        $display("test pins off done");
        give_verdict();
    end
endmodule : clocked_serial_io_port_bench
